/* ascp_core.v */
`timescale 1ns/1ps
// Behaviour
// - Mode 1 only: clock idles low.
// - Chip select high resets port, output released.
// - Ready flag falls on new result, rises on rise.
// - Unread continuous: ready pulses high two periods.
// - Ready flag always driven.
// - Sample input on falling clock; never drive it.
// - Output changes on rising clock edges.
// - Optional ready shown on shared output pin.
// - Incomplete command times out, port resets.
// - Result is 16 bits, MSB first.
// - Results saturate at 7FFF and 8000.
// - Reset command restores register defaults.
// - Single-shot start restarts one conversion.
// - Continuous start begins or restarts conversions.
// - Sleep after current conversion, registers kept.
// - Read command loads newest result.
// - Ready stays low if older result read.
// - Register read shifts out nn+1 bytes.
// - Register write updates on last falling edge.
// - Result readable directly after ready falls.
// - Decode commands during direct reads.
// - No decoding during read commands.
// - Four 8-bit registers, reset zero.
`include "ascp_defs.vh"
module ascp_core #(
  parameter MOD_DIV = 16  // System clocks per modulator period
) (
  // Clock and reset
  input  wire        clk_in,
  input  wire        rst_b_in,
  // Serial pins
  input  wire        sclk_in,
  input  wire        cs_n_in,
  input  wire        din_in,
  output reg         serial_out_ready_out,
  output reg         serial_out_ready_oe_out,
  output reg         conv_ready_n_out,
  // Conversion engine side
  input  wire        conv_done_in,
  input  wire signed [17:0] conv_raw_in,
  output reg         conv_start_out,
  output reg         conv_sleep_out,
  output reg         conv_cont_out,
  output reg         conv_turbo_out,
  // Configuration view
  output reg  [31:0] cfg_out
);
  // Synchronised pins
  wire [2:0] pin_s;
  wire       sclk_s = pin_s[2];
  wire       cs_n_s = pin_s[1];
  wire       din_s  = pin_s[0];
  reg        sclk_d;                // Previous sampled clock
  wire       sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
  wire       sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;

  ascp_sync #(.W(3)) u_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     ({sclk_in, cs_n_in, din_in}),
    .q_out    (pin_s)
  );

  // Protocol state
  localparam ST_CMD  = 2'd0;        // Decoding command bytes
  localparam ST_RDAT = 2'd1;        // Shifting result out
  localparam ST_REG_READ_CMD = 2'd2;        // Shifting registers out
  localparam ST_REG_WRITE_CMD = 2'd3;        // Taking register bytes

  reg  [1:0]  state;                // Current state
  reg  [7:0]  cfg [0:3];            // Configuration registers
  reg  [7:0]  wbuf [0:3];           // Staged write bytes
  reg  [15:0] result;               // Newest stored result
  reg  [15:0] shreg;                // Output shift register
  reg  [7:0]  inreg;                // Input shift register
  reg  [2:0]  bitcnt;               // Bit within byte
  reg  [1:0]  bytecnt;              // Byte within transfer
  reg  [1:0]  raddr;                // Register start address
  reg  [1:0]  rcount;               // Bytes remaining minus one
  reg         direct;               // Direct result read in progress
  reg         dbyte;                // Direct read second byte
  reg  [3:0]  modcnt;               // Modulator period divider
  reg  [15:0] tocnt;                // Timeout counter
  reg  [1:0]  pulsecnt;             // Ready high pulse length
  reg         unread;               // Result not read yet
  reg         sleep_pend;           // Sleep awaiting conversion end
  integer     i;

  // Sized copies of the timing counts
  localparam [15:0] TO_NORM   = `ASCP_TIMEOUT_NORM;
  localparam [15:0] TO_TURBO  = `ASCP_TIMEOUT_TURBO;
  localparam [1:0]  PULSE_ARM = `ASCP_RDY_PULSE_MOD + 1;  // One extra tick so the gap spans two full periods

  wire        mod_tick = (modcnt == MOD_DIV[3:0] - 4'd1);
  wire        rdy_sel  = cfg[`ASCP_RDYSEL_REG][`ASCP_RDYSEL_BIT];
  wire [15:0] to_lim   = cfg[`ASCP_TURBO_REG][`ASCP_TURBO_BIT] ?
                         TO_TURBO : TO_NORM;
  wire [7:0]  next_in  = {inreg[6:0], din_s};
  wire        byte_end = sclk_fall & (bitcnt == 3'd7);
  wire        busy     = (state != ST_CMD) | (bitcnt != 3'd0) | direct;

  // Clip an 18-bit raw value into 16 bits
  function [15:0] sat16;
    input signed [17:0] v;
    begin
      if (v > 18'sd32767)
        sat16 = `ASCP_SAT_POS;
      else if (v < -18'sd32768)
        sat16 = `ASCP_SAT_NEG;
      else
        sat16 = v[15:0];
    end
  endfunction

  // Modulator period divider
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      modcnt <= 4'h0;
    else
      modcnt <= mod_tick ? 4'h0 : modcnt + 4'd1;
  end

  // Clock history; sampled every cycle, edges gated by chip select
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      sclk_d <= 1'b0;
    else
      sclk_d <= sclk_s;
  end

  // Serial engine
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state          <= ST_CMD;
      for (i = 0; i < 4; i = i + 1) begin
        cfg[i]  <= `ASCP_CFG_RESET;
        wbuf[i] <= 8'h00;
      end
      result         <= 16'h0000;
      shreg          <= 16'h0000;
      inreg          <= 8'h00;
      bitcnt         <= 3'd0;
      bytecnt        <= 2'd0;
      raddr          <= 2'd0;
      rcount         <= 2'd0;
      direct         <= 1'b0;
      dbyte          <= 1'b0;
      tocnt          <= 16'h0000;
      pulsecnt       <= 2'd0;
      unread         <= 1'b0;
      sleep_pend     <= 1'b0;
      conv_start_out <= 1'b0;
      conv_sleep_out <= 1'b0;
      conv_ready_n_out        <= 1'b1;
      serial_out_ready_out    <= 1'b1;
      serial_out_ready_oe_out <= 1'b0;
    end else begin
      conv_start_out <= 1'b0;
      // Output pin enable follows chip select
      serial_out_ready_oe_out <= ~cs_n_s;
      // Ready pulse before next result when unread
      if (mod_tick && pulsecnt != 2'd0)
        pulsecnt <= pulsecnt - 2'd1;
      // New conversion result
      if (conv_done_in) begin
        result <= sat16(conv_raw_in);
        unread <= 1'b1;
        // Unread result in continuous mode: hold high, fall after the gap
        if (unread && conv_cont_out)
          conv_ready_n_out <= 1'b1;
        else
          conv_ready_n_out <= 1'b0;
        if (rdy_sel && !busy)
          serial_out_ready_out <= 1'b0;
        if (sleep_pend) begin
          conv_sleep_out <= 1'b1;
          sleep_pend     <= 1'b0;
        end
      end else if (mod_tick && pulsecnt == 2'd1) begin
        conv_ready_n_out <= 1'b0;
      end
      // Timeout counter
      if (cs_n_s || !busy || sclk_fall)
        tocnt <= 16'h0000;
      else if (mod_tick)
        tocnt <= tocnt + 16'd1;
      if (cs_n_s || (tocnt >= to_lim)) begin
        // Port reset: discard partial byte
        state   <= ST_CMD;
        bitcnt  <= 3'd0;
        bytecnt <= 2'd0;
        direct  <= 1'b0;
        dbyte   <= 1'b0;
        tocnt   <= 16'h0000;
      end else begin
        // Rising edge: shift data out
        if (sclk_rise) begin
          // A result landing in the same cycle wins
          if (!conv_done_in)
            conv_ready_n_out <= 1'b1;
          if (bitcnt == 3'd0 && state == ST_CMD && !direct && unread) begin
            // Direct read begins
            direct <= 1'b1;
            dbyte  <= 1'b0;
            unread <= conv_done_in;   // Set wins over clear
            serial_out_ready_out <= result[15];
            shreg  <= {result[14:0], 1'b0};
          end else if (state == ST_CMD && !direct) begin
            serial_out_ready_out <= 1'b1;
          end else begin
            serial_out_ready_out <= shreg[15];
            shreg <= {shreg[14:0], 1'b0};
          end
        end
        // Falling edge: sample input
        if (sclk_fall) begin
          inreg  <= next_in;
          bitcnt <= bitcnt + 3'd1;
        end
        if (byte_end) begin
          if (direct && !dbyte)
            dbyte <= 1'b1;
          else if (direct)
            direct <= 1'b0;
          case (state)
            ST_CMD: begin
              // Decode at byte boundaries, also during direct reads
              if (next_in[7:1] == `ASCP_CMD_RESET) begin
                for (i = 0; i < 4; i = i + 1)
                  cfg[i] <= `ASCP_CFG_RESET;
              end else if (next_in[7:1] == `ASCP_CMD_START) begin
                conv_start_out <= 1'b1;
                conv_sleep_out <= 1'b0;
                sleep_pend     <= 1'b0;
              end else if (next_in[7:1] == `ASCP_CMD_SLEEP) begin
                sleep_pend <= 1'b1;
              end else if (next_in[7:4] == `ASCP_CMD_RDATA) begin
                // Older result if one lands this cycle
                shreg  <= result;
                unread <= conv_done_in;
                direct <= 1'b0;
                state  <= ST_RDAT;
                bytecnt <= 2'd1;
              end else if (next_in[7:4] == `ASCP_CMD_REG_READ_CMD) begin
                shreg  <= {cfg[next_in[3:2]], 8'h00};
                raddr  <= next_in[3:2] + 2'd1;
                rcount <= next_in[1:0];
                direct <= 1'b0;
                state  <= ST_REG_READ_CMD;
              end else if (next_in[7:4] == `ASCP_CMD_REG_WRITE_CMD) begin
                raddr   <= next_in[3:2];
                rcount  <= next_in[1:0];
                bytecnt <= 2'd0;
                state   <= ST_REG_WRITE_CMD;
              end
              // Anything else is ignored
            end
            ST_RDAT: begin
              // No decoding until 16 bits are out
              if (bytecnt == 2'd0)
                state <= ST_CMD;
              bytecnt <= bytecnt - 2'd1;
            end
            ST_REG_READ_CMD: begin
              if (rcount == 2'd0) begin
                state <= ST_CMD;
              end else begin
                shreg  <= {cfg[raddr], 8'h00};
                raddr  <= raddr + 2'd1;
                rcount <= rcount - 2'd1;
              end
            end
            ST_REG_WRITE_CMD: begin
              wbuf[bytecnt] <= next_in;
              bytecnt <= bytecnt + 2'd1;
              if (bytecnt == rcount) begin
                // Commit all bytes on the final falling edge
                for (i = 0; i < 4; i = i + 1)
                  if (i[1:0] <= bytecnt)
                    cfg[raddr + i[1:0]] <= (i[1:0] == bytecnt) ? next_in : wbuf[i];
                conv_start_out <= 1'b1;
                conv_sleep_out <= 1'b0;
                state <= ST_CMD;
              end
            end
            default: state <= ST_CMD;
          endcase
        end
      end
      // Pulse arm: unread result in continuous mode
      if (conv_done_in && unread && conv_cont_out)
        pulsecnt <= PULSE_ARM;
    end
  end

  // Registered configuration view
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      cfg_out <= 32'h0;
    else
      cfg_out <= {cfg[3], cfg[2], cfg[1], cfg[0]};
  end

  // Mode outputs
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      conv_cont_out  <= 1'b0;
      conv_turbo_out <= 1'b0;
    end else begin
      conv_cont_out  <= cfg[`ASCP_CM_REG][`ASCP_CM_BIT];
      conv_turbo_out <= cfg[`ASCP_TURBO_REG][`ASCP_TURBO_BIT];
    end
  end
endmodule

/* ascp_defs.vh */
`ifndef ASCP_DEFS_VH
`define ASCP_DEFS_VH
// Command byte patterns
`define ASCP_CMD_RESET      7'h03
`define ASCP_CMD_START      7'h04
`define ASCP_CMD_SLEEP      7'h01
`define ASCP_CMD_RDATA      4'h1
`define ASCP_CMD_REG_READ_CMD       4'h2
`define ASCP_CMD_REG_WRITE_CMD       4'h4
// Config register reset value
`define ASCP_CFG_RESET      8'h00
// Field positions in the config registers
`define ASCP_CM_REG         2
`define ASCP_CM_BIT         2
`define ASCP_TURBO_REG      1
`define ASCP_TURBO_BIT      4
`define ASCP_RDYSEL_REG     3
`define ASCP_RDYSEL_BIT     1
// Timing counts in modulator periods
`define ASCP_TIMEOUT_NORM   13955
`define ASCP_TIMEOUT_TURBO  27910
`define ASCP_RDY_PULSE_MOD  2
// Saturation codes
`define ASCP_SAT_POS        16'h7FFF
`define ASCP_SAT_NEG        16'h8000
`endif

/* ascp_sync.v */
`timescale 1ns/1ps
// Two-flop synchroniser for a vector of asynchronous inputs
module ascp_sync #(
  parameter W = 3
) (
  // Clock and reset
  input  wire         clk_in,
  input  wire         rst_b_in,
  // Data
  input  wire [W-1:0] d_in,
  output reg  [W-1:0] q_out
);
  reg [W-1:0] meta;  // First stage, read only by q_out

  // Double registering
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta  <= {W{1'b0}};
      q_out <= {W{1'b0}};
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule

/* ascp_core_checker.sv */
`timescale 1ns/1ps
// Port-level checks of the serial command port
module ascp_core_checker #(
  parameter MOD_DIV = 16
) (
  // Clock, reset, host pins
  input wire        clk_in,
  input wire        rst_b_in,
  input wire        sclk_in,
  input wire        cs_n_in,
  // Engine and outputs
  input wire        conv_done_in,
  input wire        serial_out_ready_out,
  input wire        serial_out_ready_oe_out,
  input wire        conv_ready_n_out,
  input wire        conv_start_out,
  input wire        conv_cont_out,
  input wire [31:0] cfg_out
);
  reg [3:0] since_rise;  // Cycles since serial clock rose
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Age of the last serial clock rise
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) since_rise <= 4'hF;
    else if ($rose(sclk_in)) since_rise <= 4'h0;
    else if (since_rise != 4'hF) since_rise <= since_rise + 4'h1;
  end
  a_oe_release: assert property (cs_n_in [*5] |-> !serial_out_ready_oe_out)
    else $error("Output driven while deselected");
  a_oe_drive: assert property (!cs_n_in [*5] |-> serial_out_ready_oe_out)
    else $error("Output not driven while selected");
  a_rdy_clear: assert property ($rose(sclk_in) && !cs_n_in && !conv_ready_n_out && !conv_done_in
    |-> ##[1:6] conv_ready_n_out) else $error("Ready not cleared by clock rise");
  a_rdy_fall: assert property ($rose(conv_done_in) |-> ##[1:40] !conv_ready_n_out)
    else $error("Ready did not fall on result");
  a_rdy_gap: assert property (conv_done_in && !conv_ready_n_out && conv_cont_out
    |-> ##[1:40] conv_ready_n_out ##[1:40] !conv_ready_n_out) else $error("No ready gap");
  a_rdy_on_dout: assert property ($fell(conv_ready_n_out) && cfg_out[25] && !cs_n_in
    && serial_out_ready_oe_out |-> ##[0:1] !serial_out_ready_out) else $error("Pin ready missing");
  a_dout_on_rise: assert property ($changed(serial_out_ready_out) && serial_out_ready_oe_out
    && $past(serial_out_ready_oe_out, 2) && !cfg_out[25] |-> since_rise < 4'h9)
    else $error("Output changed away from clock rise");
  a_start_single: assert property (conv_start_out |=> !conv_start_out)
    else $error("Start strobe too long");
  a_cont_field: assert property ($changed(cfg_out[18]) |-> ##[0:2] conv_cont_out == cfg_out[18])
    else $error("Continuous level off its field");
  c_start: cover property ($rose(conv_start_out));
  c_pin_ready: cover property ($fell(conv_ready_n_out) && cfg_out[25]);
  c_gap: cover property (conv_done_in && !conv_ready_n_out && conv_cont_out);
endmodule
bind ascp_core ascp_core_checker #(.MOD_DIV(MOD_DIV)) ascp_core_checker_i (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in),
  .conv_done_in(conv_done_in), .serial_out_ready_out(serial_out_ready_out),
  .serial_out_ready_oe_out(serial_out_ready_oe_out), .conv_ready_n_out(conv_ready_n_out),
  .conv_start_out(conv_start_out), .conv_cont_out(conv_cont_out), .cfg_out(cfg_out));

/* ascp_host.sv */
`timescale 1ns/1ps
// Mode 1 host that frames and clocks transfers
module ascp_host (
  // Pacing clock
  input  wire clk_in,
  // Host pins
  output reg  sclk_out,
  output reg  cs_n_out,
  output reg  din_out,
  // Device output pin
  input  wire so_in,
  input  wire so_oe_in
);
  // Clock idles low, device deselected
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out = 1'b0;
  end
  // Select stays for the whole command
  task sel(input logic b);
    @(negedge clk_in);
    cs_n_out = ~b;
    repeat (10) @(negedge clk_in);
  endtask
  // Change on rise, sample on fall, MSB first
  task xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    for (i = 0; i < n; i++) begin
      @(negedge clk_in);
      din_out = tx[7-i];
      sclk_out = 1'b1;
      repeat (10) @(negedge clk_in);
      sclk_out = 1'b0;
      rx = {rx[6:0], so_oe_in ? so_in : ~rx[0]};
      repeat (9) @(negedge clk_in);
    end
  endtask
endmodule

/* adc_serial_command_port_tb_top.sv */
`timescale 1ns/1ps
// Bench for the serial command port
module adc_serial_command_port_tb_top;
  reg          clk_in = 1'b0;
  reg          rst_b_in = 1'b0;
  reg          conv_done_in = 1'b0;
  reg  [17:0]  conv_raw_in = 18'h00000;
  wire         sclk, cs_n, din, so, so_oe, rdy_n, start, sleep, cont;
  wire [31:0]  cfg;
  int          fails = 0, total_checks = 0, starts = 0, k, j;
  logic [7:0]  r, hi, lo;
  logic [31:0] w;
  // Rows: read command used, raw value, expected code
  logic [34:0] rows [6] = '{{1'b0, 18'h00123, 16'h0123}, {1'b1, 18'h1FFFF, 16'h7FFF},
    {1'b0, 18'h20000, 16'h8000}, {1'b1, 18'h3FFFF, 16'hFFFF},
    {1'b0, 18'h08000, 16'h7FFF}, {1'b1, 18'h37FFF, 16'h8000}};
  always #4 clk_in = ~clk_in;
  // Count start strobes
  always @(posedge clk_in) if (start === 1'b1) starts <= starts + 1;
  ascp_core #(.MOD_DIV(2)) ascp_core_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .din_in(din), .serial_out_ready_out(so), .serial_out_ready_oe_out(so_oe),
    .conv_ready_n_out(rdy_n), .conv_done_in(conv_done_in), .conv_raw_in(conv_raw_in),
    .conv_start_out(start), .conv_sleep_out(sleep), .conv_cont_out(cont), .conv_turbo_out(),
    .cfg_out(cfg));
  ascp_host ascp_host_i (.clk_in(clk_in), .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din),
    .so_in(so), .so_oe_in(so_oe));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task b(input logic [7:0] t, output logic [7:0] q);
    ascp_host_i.xfer(t, 8, q);
  endtask
  // One result strobe from the engine
  task done(input logic [17:0] v);
    @(negedge clk_in);
    conv_done_in = 1'b1;
    conv_raw_in = v;
    @(negedge clk_in);
    conv_done_in = 1'b0;
    repeat (60) @(negedge clk_in);
  endtask
  task close_out;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (4) @(negedge clk_in);
    chk(cfg, 32'h0);
    chk(so_oe, 1'b0);
    for (k = 0; k < 6; k++) begin
      done(rows[k][33:16]);
      chk(rdy_n, 1'b0);
      ascp_host_i.sel(1'b1);
      if (rows[k][34]) b(8'h10, r);
      b(8'h00, hi);
      b(8'h00, lo);
      ascp_host_i.sel(1'b0);
      chk({hi, lo}, rows[k][15:0]);
      chk(rdy_n, 1'b1);
      $display("Row %0d done", k);
    end
    w = 32'h44332211;
    ascp_host_i.sel(1'b1);
    b(8'h43, r);
    for (j = 0; j < 4; j++) b(w[j*8 +: 8], r);
    ascp_host_i.sel(1'b0);
    chk(cfg, w);
    ascp_host_i.sel(1'b1);
    ascp_host_i.xfer(8'hF0, 4, r);
    ascp_host_i.sel(1'b0);
    ascp_host_i.sel(1'b1);
    b(8'hFF, r);
    b(8'h2B, r);
    for (j = 0; j < 4; j++) begin
      b(8'h00, r);
      chk(r, w[((j + 2) % 4)*8 +: 8]);
    end
    b(8'h10, r);
    b(8'h07, r);
    b(8'h07, r);
    ascp_host_i.sel(1'b0);
    chk(cfg, w);
    $display("Register test done");
    j = starts;
    ascp_host_i.sel(1'b1);
    b(8'h09, r);
    repeat (10) @(negedge clk_in);
    chk(starts - j, 32'h1);
    b(8'h03, r);
    repeat (10) @(negedge clk_in);
    chk(sleep, 1'b0);
    done(18'h00055);
    chk(sleep, 1'b1);
    b(8'h08, r);
    ascp_host_i.sel(1'b0);
    chk(sleep, 1'b0);
    chk(cfg, w);
    ascp_host_i.sel(1'b1);
    b(8'h48, r);
    b(8'h37, r);
    b(8'h4C, r);
    b(8'h46, r);
    chk(cont, 1'b1);
    done(18'h00100);
    chk(so, 1'b0);
    done(18'h00200);
    chk(rdy_n, 1'b0);
    ascp_host_i.sel(1'b0);
    $display("Command test done");
    ascp_host_i.sel(1'b1);
    b(8'h07, r);
    ascp_host_i.sel(1'b0);
    repeat (6300) @(negedge clk_in);
    chk(cfg, 32'h0);
    ascp_host_i.sel(1'b1);
    ascp_host_i.xfer(8'hFF, 4, r);
    repeat (28500) @(negedge clk_in);
    b(8'h40, r);
    b(8'h5A, r);
    ascp_host_i.sel(1'b0);
    chk(cfg, 32'h5A);
    $display("Reset and timeout test done");
    close_out;
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_in);
    fails++;
    close_out;
  end
endmodule
